//--- rtl/nfc_pkg.sv
// Package of constants for the NAND flash host controller.
package nfc_pkg;
  // Avalon register word offsets (byte address = 4 * index).
  localparam logic [3:0] NFC_REG_CTRL   = 4'h0;
  localparam logic [3:0] NFC_REG_SRC    = 4'h1;
  localparam logic [3:0] NFC_REG_DST    = 4'h2;
  localparam logic [3:0] NFC_REG_STAT   = 4'h3;
  localparam logic [3:0] NFC_REG_RESULT = 4'h4;
  // Control register fields.
  localparam int NFC_CTRL_OP_LSB = 0;
  localparam int NFC_CTRL_START  = 4;
  localparam int NFC_CTRL_WP     = 8;
  // Operation codes written by software.
  localparam logic [2:0] NFC_OP_COPY   = 3'h1;
  localparam logic [2:0] NFC_OP_ERASE  = 3'h2;
  localparam logic [2:0] NFC_OP_RESET  = 3'h3;
  localparam logic [2:0] NFC_OP_STATUS = 3'h4;
  localparam logic [2:0] NFC_OP_SIG    = 3'h5;
  // Flash command codes.
  localparam logic [7:0] NFC_CMD_READ_A  = 8'h00;
  localparam logic [7:0] NFC_CMD_COPY2   = 8'h8A;
  localparam logic [7:0] NFC_CMD_CONFIRM = 8'h10;
  localparam logic [7:0] NFC_CMD_ERASE1  = 8'h60;
  localparam logic [7:0] NFC_CMD_ERASE2  = 8'hD0;
  localparam logic [7:0] NFC_CMD_RESET   = 8'hFF;
  localparam logic [7:0] NFC_CMD_STATUS  = 8'h70;
  localparam logic [7:0] NFC_CMD_SIG     = 8'h90;
  localparam logic [7:0] NFC_ADDR_ZERO   = 8'h00;
  // Status byte fields.
  localparam int NFC_SR_FAIL  = 0;
  localparam int NFC_SR_READY = 6;
  localparam int NFC_SR_WP    = 7;
  // Address field positions.
  localparam int NFC_PLANE_BIT_SMALL = 23;
  localparam int NFC_PLANE_BIT_LARGE = 24;
  localparam logic [7:0] NFC_ERASE_HI_MASK = 8'h03;
  localparam int NFC_ADDR_CYCLES  = 4;
  localparam int NFC_ERASE_CYCLES = 2;
  // Strobe phase timing: 30 ns per phase at 100 MHz, rounded up.
  localparam int NFC_CLK_PERIOD_NS = 10;
  localparam int NFC_PHASE_NS      = 30;
  localparam int NFC_PHASE_CYC =
    (NFC_PHASE_NS + NFC_CLK_PERIOD_NS - 1) / NFC_CLK_PERIOD_NS;
  // Settle time before busy is trusted: 100 ns.
  localparam int NFC_BUSY_WAIT_NS  = 100;
  localparam int NFC_BUSY_WAIT_CYC =
    (NFC_BUSY_WAIT_NS + NFC_CLK_PERIOD_NS - 1) / NFC_CLK_PERIOD_NS;
endpackage : nfc_pkg

//--- rtl/nfc_strobe.sv
// Bus cycle engine that drives one command, address or read cycle on the flash pins.
`timescale 1ns/1ps
module nfc_strobe
  import nfc_pkg::*;
(
  input  wire logic       clk,       // System clock.
  input  wire logic       rst,       // Synchronous reset, active high.
  input  wire logic       go,        // Start one bus cycle.
  input  wire logic [1:0] kind,      // 0 command, 1 address, 2 data read.
  input  wire logic [7:0] wdata,     // Byte to drive.
  input  wire logic [7:0] pin_in,    // Synchronised data lines.
  output logic            done,      // One-cycle pulse at cycle end.
  output logic [7:0]      rdata,     // Byte sampled on a read.
  output logic            cle,       // Command latch enable.
  output logic            ale,       // Address latch enable.
  output logic            we_n,      // Write enable, active low.
  output logic            re_n,      // Read enable, active low.
  output logic [7:0]      io_out,    // Data lines out.
  output logic            io_oe      // Data line output enable.
);
  typedef enum logic [1:0] {NFC_S_IDLE, NFC_S_LOW, NFC_S_HIGH} nfc_sst_e;
  nfc_sst_e   st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] kind_reg, kind_next;
  logic [7:0] wd_reg, wd_next, rd_reg, rd_next;
  logic       done_next;
  logic       done_reg;

  // Each cycle holds the strobe low one phase, then high one phase.
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    kind_next = kind_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    done_next = 1'b0;
    unique case (st_reg)
      NFC_S_IDLE: begin
        if (go) begin
          st_next   = NFC_S_LOW;
          kind_next = kind;
          wd_next   = wdata;
          cnt_next  = 4'(NFC_PHASE_CYC - 1);
        end
      end
      NFC_S_LOW: begin
        if (cnt_reg == 4'h0) begin
          if (kind_reg == 2'h2) begin
            rd_next = pin_in;
          end
          st_next  = NFC_S_HIGH;
          cnt_next = 4'(NFC_PHASE_CYC - 1);
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      NFC_S_HIGH: begin
        if (cnt_reg == 4'h0) begin
          st_next   = NFC_S_IDLE;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: st_next = NFC_S_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg   <= NFC_S_IDLE;
      cnt_reg  <= 4'h0;
      kind_reg <= 2'h0;
      wd_reg   <= 8'h00;
      rd_reg   <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      kind_reg <= kind_next;
      wd_reg   <= wd_next;
      rd_reg   <= rd_next;
      done_reg <= done_next;
    end
  end

  // Pin decode from the current cycle.
  assign done   = done_reg;
  assign rdata  = rd_reg;
  assign cle    = (st_reg != NFC_S_IDLE) && (kind_reg == 2'h0);
  assign ale    = (st_reg != NFC_S_IDLE) && (kind_reg == 2'h1);
  assign we_n   = !((st_reg == NFC_S_LOW) && (kind_reg != 2'h2));
  assign re_n   = !((st_reg == NFC_S_LOW) && (kind_reg == 2'h2));
  assign io_oe  = (st_reg != NFC_S_IDLE) && (kind_reg != 2'h2);
  assign io_out = wd_reg;
endmodule : nfc_strobe

//--- rtl/nfc_host.sv
// Host controller that sequences copy-back, erase, reset, status and signature operations.
`timescale 1ns/1ps
module nfc_host
  import nfc_pkg::*;
#(
  parameter int ADDR_W = 32                        // Page address register width.
)
(
  input  wire logic              clk,              // System clock, 100 MHz.
  input  wire logic              rst,              // Synchronous reset, active high.
  input  wire logic [3:0]        avs_address,      // Avalon word address.
  input  wire logic              avs_read,         // Avalon read.
  input  wire logic              avs_write,        // Avalon write.
  input  wire logic [31:0]       avs_writedata,    // Avalon write data.
  input  wire logic [3:0]        avs_byteenable,   // Avalon byte enables.
  output logic [31:0]            avs_readdata,     // Avalon read data.
  output logic                   avs_waitrequest,  // Avalon wait request.
  output logic                   flash_cle,        // Command latch enable.
  output logic                   flash_ale,        // Address latch enable.
  output logic                   flash_ce_n,       // Chip enable, active low.
  output logic                   flash_we_n,       // Write enable, active low.
  output logic                   flash_re_n,       // Read enable, active low.
  output logic                   flash_wp_n,       // Write protect, active low.
  output logic [7:0]             flash_io_out,     // Data lines out.
  output logic                   flash_io_oe,      // Data lines output enable.
  input  wire logic [7:0]        flash_io_in,      // Data lines in.
  input  wire logic              flash_rb          // Ready/busy, low while busy.
);
  typedef enum logic [3:0] {
    NFC_IDLE, NFC_CMD1, NFC_ADDR1, NFC_CMD2, NFC_ADDR2,
    NFC_CMD3, NFC_WAITF, NFC_STCMD, NFC_RD1
  } nfc_st_e;

  nfc_st_e             st_reg, st_next;
  logic [2:0]          op_reg, op_next;
  logic                wp_reg, wp_next;
  logic [ADDR_W-1:0]   src_reg, src_next, dst_reg, dst_next;
  logic [2:0]          ac_reg, ac_next;
  logic [3:0]          wt_reg, wt_next;
  logic [7:0]          sr_reg, sr_next, b0_reg, b0_next, b1_reg, b1_next;
  logic                err_reg, err_next;
  logic                ack_reg, ack_next;
  logic [31:0]         rd_reg, rd_next;
  logic [7:0]          io_s1_reg, io_s2_reg;
  logic                rb_s1_reg, rb_s2_reg;
  logic                go, sdone, busy;
  logic [1:0]          kind;
  logic [7:0]          wbyte, sdata;

  // Picks address byte n of a page address.
  function automatic logic [7:0] nfc_abyte(input logic [ADDR_W-1:0] a,
                                           input logic [2:0] n);
    nfc_abyte = 8'(a >> (8 * n));
  endfunction : nfc_abyte

  // Two-flop synchronisers for the flash pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end else begin
      io_s1_reg <= flash_io_in;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= flash_rb;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  assign busy = (st_reg != NFC_IDLE);

  nfc_strobe u_strobe (
    .clk    (clk),
    .rst    (rst),
    .go     (go),
    .kind   (kind),
    .wdata  (wbyte),
    .pin_in (io_s2_reg),
    .done   (sdone),
    .rdata  (sdata),
    .cle    (flash_cle),
    .ale    (flash_ale),
    .we_n   (flash_we_n),
    .re_n   (flash_re_n),
    .io_out (flash_io_out),
    .io_oe  (flash_io_oe)
  );

  // Sequencer and register file next-state logic.
  always_comb begin
    st_next  = st_reg;
    op_next  = op_reg;
    wp_next  = wp_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    ac_next  = ac_reg;
    wt_next  = wt_reg;
    sr_next  = sr_reg;
    b0_next  = b0_reg;
    b1_next  = b1_reg;
    err_next = err_reg;
    ack_next = 1'b0;
    rd_next  = rd_reg;
    go       = 1'b0;
    kind     = 2'h0;
    wbyte    = 8'h00;
    // Avalon slave: one-cycle wait, then ack.
    if ((avs_read || avs_write) && !ack_reg) begin
      ack_next = 1'b1;
      rd_next  = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          NFC_REG_CTRL:   rd_next = {23'h0, wp_reg, 4'h0, 1'b0, op_reg};
          NFC_REG_SRC:    rd_next = 32'(src_reg);
          NFC_REG_DST:    rd_next = 32'(dst_reg);
          NFC_REG_STAT:   rd_next = {30'h0, err_reg, busy};
          NFC_REG_RESULT: rd_next = {8'h00, b1_reg, b0_reg, sr_reg};
          default:        rd_next = 32'h0000_0000;
        endcase
      end else if (avs_byteenable[0] && !busy) begin
        unique case (avs_address)
          NFC_REG_CTRL: begin
            op_next = avs_writedata[NFC_CTRL_OP_LSB +: 3];
            wp_next = avs_writedata[NFC_CTRL_WP];
          end
          NFC_REG_SRC: src_next = ADDR_W'(avs_writedata);
          NFC_REG_DST: dst_next = ADDR_W'(avs_writedata);
          default: ;
        endcase
      end
    end
    unique case (st_reg)
      NFC_IDLE: begin
        if (avs_write && !ack_reg && avs_address == NFC_REG_CTRL && avs_byteenable[0]
            && avs_writedata[NFC_CTRL_START]) begin
          op_next  = avs_writedata[NFC_CTRL_OP_LSB +: 3];
          err_next = 1'b0;
          ac_next  = 3'h0;
          if (avs_writedata[NFC_CTRL_OP_LSB +: 3] == NFC_OP_COPY
              && (src_reg[NFC_PLANE_BIT_SMALL] != dst_reg[NFC_PLANE_BIT_SMALL]
               || src_reg[NFC_PLANE_BIT_LARGE] != dst_reg[NFC_PLANE_BIT_LARGE])) begin
            err_next = 1'b1;
          end else begin
            st_next = NFC_CMD1;
          end
        end
      end
      NFC_CMD1: begin
        go = 1'b1;
        // each operation opens with its own command, never a program
        unique case (op_reg)
          NFC_OP_COPY:   wbyte = NFC_CMD_READ_A;   // read setup
          NFC_OP_ERASE:  wbyte = NFC_CMD_ERASE1;   // erase setup
          NFC_OP_RESET:  wbyte = NFC_CMD_RESET;    // reset command
          NFC_OP_STATUS: wbyte = NFC_CMD_STATUS;
          NFC_OP_SIG:    wbyte = NFC_CMD_SIG;      // signature command
          default:       wbyte = NFC_CMD_RESET;
        endcase
        st_next = NFC_WAITF;
        wt_next = 4'(NFC_BUSY_WAIT_CYC);
        if (op_reg == NFC_OP_COPY || op_reg == NFC_OP_ERASE || op_reg == NFC_OP_SIG) begin
          st_next = NFC_ADDR1;
        end else if (op_reg == NFC_OP_STATUS) begin
          st_next = NFC_STCMD;
        end
      end
      NFC_ADDR1: begin
        // Each address byte follows the end of the previous bus cycle.
        kind = 2'h1;
        go   = sdone;
        if (op_reg == NFC_OP_SIG) begin
          wbyte = NFC_ADDR_ZERO;
        end else if (op_reg == NFC_OP_ERASE) begin
          wbyte = nfc_abyte(src_reg, 3'(ac_reg + 3'h1));
          if (ac_reg == 3'(NFC_ERASE_CYCLES - 1)) begin
            wbyte = wbyte & NFC_ERASE_HI_MASK;
          end
        end else begin
          wbyte = nfc_abyte(src_reg, ac_reg);
        end
        if (go) begin
          ac_next = ac_reg + 3'h1;
          if (op_reg == NFC_OP_SIG) begin
            st_next = NFC_RD1;
          end else if (op_reg == NFC_OP_ERASE && ac_reg == 3'(NFC_ERASE_CYCLES - 1)) begin
            st_next = NFC_CMD3;
          end else if (ac_reg == 3'(NFC_ADDR_CYCLES - 1)) begin
            st_next = NFC_WAITF;
            wt_next = 4'(NFC_BUSY_WAIT_CYC);
          end
        end
      end
      NFC_CMD2: begin
        go      = 1'b1;
        wbyte   = NFC_CMD_COPY2;
        ac_next = 3'h0;
        st_next = NFC_ADDR2;
      end
      NFC_ADDR2: begin
        kind  = 2'h1;
        wbyte = nfc_abyte(dst_reg, ac_reg);
        go    = sdone;
        if (go) begin
          ac_next = ac_reg + 3'h1;
          if (ac_reg == 3'(NFC_ADDR_CYCLES - 1)) begin
            st_next = NFC_CMD3;
          end
        end
      end
      NFC_CMD3: begin
        go    = sdone;
        wbyte = (op_reg == NFC_OP_ERASE) ? NFC_CMD_ERASE2 : NFC_CMD_CONFIRM;
        if (go) begin
          st_next = NFC_WAITF;
          wt_next = 4'(NFC_BUSY_WAIT_CYC);
          ac_next = 3'h0;
        end
      end
      NFC_WAITF: begin
        // wait the settle time, then for ready high
        if (wt_reg != 4'h0) begin
          wt_next = wt_reg - 4'h1;
        end else if (rb_s2_reg) begin
          st_next = (op_reg == NFC_OP_RESET) ? NFC_IDLE : NFC_STCMD;
          // source page loaded, second copy command next
          if (ac_reg == 3'(NFC_ADDR_CYCLES)) begin
            st_next = NFC_CMD2;
          end
          ac_next = 3'h1;
        end
      end
      NFC_STCMD: begin
        // status command once unless already issued, then one status read
        wbyte = NFC_CMD_STATUS;
        kind  = (ac_reg == 3'h1) ? 2'h0 : 2'h2;
        go    = (ac_reg == 3'h1) || (sdone && ac_reg == 3'h0);
        if (go) begin
          ac_next = (ac_reg == 3'h1) ? 3'h0 : 3'h2;
        end
        if (sdone && ac_reg == 3'h2) begin
          sr_next = sdata;
          err_next = sdata[NFC_SR_FAIL] && (op_reg != NFC_OP_STATUS);
          st_next  = NFC_IDLE;
        end
      end
      NFC_RD1: begin
        // maker code read, then device code read
        kind = 2'h2;
        go   = sdone && (ac_reg != 3'h3);
        if (go) begin
          ac_next = ac_reg + 3'h1;
        end
        if (sdone && ac_reg == 3'h2) begin
          b0_next = sdata;
        end
        if (sdone && ac_reg == 3'h3) begin
          b1_next = sdata;
          st_next = NFC_IDLE;
        end
      end
      default: st_next = NFC_IDLE;
    endcase
  end

  // Sequencer and register file state.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg  <= NFC_IDLE;
      op_reg  <= 3'h0;
      wp_reg  <= 1'b0;
      src_reg <= '0;
      dst_reg <= '0;
      ac_reg  <= 3'h0;
      wt_reg  <= 4'h0;
      sr_reg  <= 8'h00;
      b0_reg  <= 8'h00;
      b1_reg  <= 8'h00;
      err_reg <= 1'b0;
      ack_reg <= 1'b0;
      rd_reg  <= 32'h0000_0000;
    end else begin
      st_reg  <= st_next;
      op_reg  <= op_next;
      wp_reg  <= wp_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      ac_reg  <= ac_next;
      wt_reg  <= wt_next;
      sr_reg  <= sr_next;
      b0_reg  <= b0_next;
      b1_reg  <= b1_next;
      err_reg <= err_next;
      ack_reg <= ack_next;
      rd_reg  <= rd_next;
    end
  end

  // Slave answers and steady pins.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata    = rd_reg;
  assign flash_ce_n      = !busy;
  assign flash_wp_n      = wp_reg;
endmodule : nfc_host

//--- testbench/nfc_host_assertions.sv
// Checker of the host controller's port behaviour.
`timescale 1ns/1ps
module nfc_host_assertions
  import nfc_pkg::*;
(
  input wire logic        clk,             // Clock.
  input wire logic        rst,             // Reset.
  input wire logic [3:0]  avs_address,     // Word address.
  input wire logic        avs_read,        // Read.
  input wire logic        avs_write,       // Write.
  input wire logic [31:0] avs_writedata,   // Write data.
  input wire logic [3:0]  avs_byteenable,  // Byte enables.
  input wire logic [31:0] avs_readdata,    // Read data.
  input wire logic        avs_waitrequest, // Wait request.
  input wire logic        flash_cle,       // Command latch.
  input wire logic        flash_ale,       // Address latch.
  input wire logic        flash_ce_n,      // Chip enable.
  input wire logic        flash_we_n,      // Write strobe.
  input wire logic        flash_re_n,      // Read strobe.
  input wire logic        flash_wp_n,      // Write protect.
  input wire logic [7:0]  flash_io_out,    // Data out.
  input wire logic        flash_io_oe,     // Data enable.
  input wire logic [7:0]  flash_io_in,     // Data in.
  input wire logic        flash_rb         // Ready/busy.
);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  // Bus answers, strobe shapes and pin ownership.
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in the next cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > NFC_REG_RESULT
    |-> avs_readdata == 32'h0) else $error("unmapped read returned nonzero data");
  a_latch_excl: assert property (!(flash_cle && flash_ale))
    else $error("command and address latch high together");
  a_strobe_excl: assert property (!(!flash_we_n && !flash_re_n))
    else $error("write and read strobes low together");
  a_we_pulse: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*3] ##1 flash_we_n[*3])
    else $error("write strobe pulse has the wrong shape");
  a_re_pulse: assert property ($fell(flash_re_n) |-> (!flash_re_n && !flash_io_oe)[*3] ##1 flash_re_n)
    else $error("read strobe pulse wrong or data lines driven");
  a_write_owned: assert property (!flash_we_n |-> flash_io_oe && !flash_ce_n
    && (flash_cle || flash_ale)) else $error("write cycle without drive or latch");
  a_write_stable: assert property (!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_io_out)
    && $stable(flash_cle) && $stable(flash_ale)) else $error("latched byte moved");
  a_reset_quiet: assert property ($past(rst) |-> flash_ce_n && flash_we_n && flash_re_n
    && !flash_cle && !flash_ale && !flash_io_oe && !flash_wp_n) else $error("pins active after reset");

  c_copy: cover property (!flash_we_n && flash_cle && flash_io_out == NFC_CMD_COPY2);
  c_erase: cover property (!flash_we_n && flash_cle && flash_io_out == NFC_CMD_ERASE2);
  c_sig: cover property (!flash_we_n && flash_cle && flash_io_out == NFC_CMD_SIG);
endmodule : nfc_host_assertions

bind nfc_host nfc_host_assertions u_chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .flash_cle(flash_cle), .flash_ale(flash_ale),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_re_n(flash_re_n),
  .flash_wp_n(flash_wp_n), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe),
  .flash_io_in(flash_io_in), .flash_rb(flash_rb));

//--- testbench/nfc_flash_model.sv
// Behavioural flash device that answers the host controller on its pins.
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter logic [7:0] MAKER_CODE  = 8'h5A, // Arbitrary maker code.
  parameter logic [7:0] DEVICE_CODE = 8'hC3, // Arbitrary device code.
  parameter int         PROG_NS     = 2000,  // Program and erase time.
  parameter int         LOAD_NS     = 500,   // Page load time.
  parameter int         RESET_NS    = 300    // Reset recovery time.
)
(
  input  wire logic       cle,    // Command latch.
  input  wire logic       ale,    // Address latch.
  input  wire logic       ce_n,   // Chip enable.
  input  wire logic       we_n,   // Write strobe.
  input  wire logic       re_n,   // Read strobe.
  input  wire logic       wp_n,   // Write protect.
  input  wire logic [7:0] io_in,  // Data lines seen.
  output logic [7:0]      io_out, // Data lines driven.
  output logic            rb      // Ready/busy.
);
  logic [9:0] log_q[$];
  logic       busy     = 1'h0;
  logic       fail     = 1'h0;
  logic       fail_inj = 1'h0;
  logic       in_reset = 1'h1;
  logic [1:0] mode     = 2'h0;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] rd_byte;
  int         n_addr   = 0;
  int         sig_idx  = 0;
  int         token    = 0;

  assign rb = ~busy;

  // Busy for a time, cut short by a newer start.
  task automatic start_busy(input int ns);
    int t;
    token++;
    t = token;
    busy = 1'h1;
    fork
      begin
        #(ns);
        if (t == token) begin
          busy = 1'h0;
        end
      end
    join_none
  endtask : start_busy

  task automatic do_cmd(input logic [7:0] cmd);
    if (busy && cmd != 8'h70 && cmd != 8'hFF) begin
      return;
    end
    n_addr = 0;
    case (cmd)
      8'h70: mode = 2'h1;
      8'hFF: if (!in_reset || busy) begin
        fail = 1'h0;
        mode = 2'h0;
        start_busy(RESET_NS);
      end
      8'h90: begin
        mode = 2'h2;
        sig_idx = 0;
      end
      8'h00, 8'h8A, 8'h60: mode = 2'h0;
      8'h10, 8'hD0: if (wp_n) begin
        fail = fail_inj;
        start_busy(PROG_NS);
      end
      default: return;
    endcase
    last_cmd = cmd;
    in_reset = (cmd == 8'hFF);
  endtask : do_cmd

  // Latch commands and addresses on the rising write strobe.
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      log_q.push_back({2'h2, io_in});
      do_cmd(io_in);
    end else if (!ce_n && ale) begin
      log_q.push_back({2'h1, io_in});
      n_addr++;
      if (last_cmd == 8'h00 && n_addr == 4) begin
        start_busy(LOAD_NS);
      end
    end
  end

  always_comb begin
    case (mode)
      2'h1: rd_byte = {wp_n, ~busy, 5'h15, fail};
      2'h2: rd_byte = (sig_idx == 0) ? MAKER_CODE : (sig_idx == 1) ? DEVICE_CODE : 8'hE7;
      default: rd_byte = 8'h3C;
    endcase
  end
  assign io_out = (!ce_n && !re_n) ? rd_byte : ~rd_byte;

  // Step through the signature codes on each read.
  always @(posedge re_n) begin
    if (!ce_n && mode == 2'h2) begin
      sig_idx++;
    end
  end
endmodule : nfc_flash_model

//--- testbench/testbench.sv
// Self-checking bench for the host controller against the flash model.
`timescale 1ns/1ps
module testbench;
  import nfc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary maker code.
  localparam logic [7:0] DEVID = 8'hC3; // Arbitrary device code.
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic        flash_cle, flash_ale, flash_ce_n, flash_we_n, flash_re_n, flash_wp_n, flash_io_oe;
  logic        flash_rb;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  flash_io_out, dev_out, io_bus;
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cycles     = 0;

  assign io_bus = flash_io_oe ? flash_io_out : dev_out;

  nfc_host dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_cle(flash_cle),
    .flash_ale(flash_ale), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_re_n(flash_re_n), .flash_wp_n(flash_wp_n), .flash_io_out(flash_io_out),
    .flash_io_oe(flash_io_oe), .flash_io_in(io_bus), .flash_rb(flash_rb));
  nfc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) flash (.cle(flash_cle),
    .ale(flash_ale), .ce_n(flash_ce_n), .we_n(flash_we_n), .re_n(flash_re_n),
    .wp_n(flash_wp_n), .io_in(io_bus), .io_out(dev_out), .rb(flash_rb));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // One bus transfer held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 100);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    check("bus answer", 32'h0, {31'h0, k == 100});
  endtask : bus

  // Start an operation and poll until it finishes.
  task automatic run_op(input logic [2:0] op, input logic wp);
    int k;
    flash.log_q.delete();
    bus(1'h1, NFC_REG_CTRL, {23'h0, wp, 3'h0, 1'h1, 1'h0, op}, 4'hF);
    k = 0;
    do begin
      bus(1'h0, NFC_REG_STAT, 32'h0, 4'hF);
      k++;
    end while (rd[0] !== 1'h0 && k < 500);
    check("operation done", 32'h0, {31'h0, rd[0]});
  endtask : run_op

  task automatic check_log(input logic [9:0] e[$]);
    check("pin cycle count", e.size(), flash.log_q.size());
    foreach (e[i]) begin
      check("pin cycle", {22'h0, e[i]}, (i < flash.log_q.size()) ? {22'h0, flash.log_q[i]} : '1);
    end
  endtask : check_log

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rst = 1'h1;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    bus(1'h1, NFC_REG_SRC, 32'h0012_3400, 4'hF);
    bus(1'h1, NFC_REG_DST, 32'h0045_6700, 4'hF);
    flash.fail_inj = 1'h1;
    run_op(NFC_OP_COPY, 1'h1);
    check_log('{10'h200, 10'h100, 10'h134, 10'h112, 10'h100, 10'h28A, 10'h100, 10'h167,
               10'h145, 10'h100, 10'h210, 10'h270});
    check("copy error", 32'h2, rd & 32'h2);
    bus(1'h0, NFC_REG_RESULT, 32'h0, 4'hF);
    check("copy status", 32'hC1, rd & 32'hC1);
    flash.fail_inj = 1'h0;
    run_op(NFC_OP_RESET, 1'h1);
    check_log('{10'h2FF});
    run_op(NFC_OP_STATUS, 1'h1);
    check_log('{10'h270});
    bus(1'h0, NFC_REG_RESULT, 32'h0, 4'hF);
    check("status after reset", 32'hC0, rd & 32'hC1);
    bus(1'h1, NFC_REG_SRC, 32'h00FF_AB00, 4'hF);
    for (int w = 1; w >= 0; w--) begin
      run_op(NFC_OP_ERASE, w[0]);
      check_log('{10'h260, 10'h1AB, 10'h103, 10'h2D0, 10'h270});
      bus(1'h0, NFC_REG_RESULT, 32'h0, 4'hF);
      check("erase status", {24'h0, w[0], 7'h40}, rd & 32'hC1);
    end
    run_op(NFC_OP_SIG, 1'h1);
    check_log('{10'h290, 10'h100});
    bus(1'h0, NFC_REG_RESULT, 32'h0, 4'hF);
    check("signature", {8'h0, DEVID, MAKER, 8'h0}, rd & 32'h00FF_FF00);
    for (int p = 0; p < 2; p++) begin
      bus(1'h1, NFC_REG_SRC, 32'h0080_0000 << p, 4'hF);
      bus(1'h1, NFC_REG_DST, 32'h0, 4'hF);
      run_op(NFC_OP_COPY, 1'h1);
      check_log('{});
      check("plane refusal", 32'h2, rd & 32'h2);
    end
    flash.log_q.delete();
    bus(1'h1, NFC_REG_CTRL, 32'h0000_0112, 4'hE);
    repeat (20) @(posedge clk);
    check_log('{});
    bus(1'h0, 4'hF, 32'h0, 4'hF);
    check("unmapped read", 32'h0, rd);
    print_verdict();
  end
endmodule : testbench
